// file: src/oms_mode_select.sv
// operating mode select, memory map gating and external bus sequencing
//
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// - pins sampled during reset, captured on reset release
// - three latched bits decode to eight modes, reserved forced peripheral
// - normal modes protect control bits, special modes relax protection
// - single chip modes drive no external bus, ports general purpose
// - expanded wide uses ports a and b as sixteen bit mux bus
// - expanded narrow: address low byte on b, byte data on a
// - narrow word transfer: high byte first, address incremented second
// - special single chip enters active background debug after reset
// - peripheral mode lets external master access on-chip peripherals
// - special expanded wide gives same bus as normal expanded wide
// - mode bits report mode, permit limited changes by writes
// - normal modes: debug needs enable command, before or with activation
// - each mode applies its own default map and bus config
// - port a/b data and direction unmapped in expanded or peripheral
// - port e unmapped in peripheral, or expanded with emulate bit
// - unimplemented locations read undefined, here zero
// - flag at bit 7, b at bit 6, a at bit 5
// - flag writable in special only, first write ignored; no peripheral via write
module oms_mode_select
   import oms_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   // mode pins
   input  wire logic        i_background_pin,
   input  wire logic        i_mode_select_b,
   input  wire logic        i_mode_select_a,
   // debug commands
   input  wire logic        i_bdm_enable_cmd,
   input  wire logic        i_bdm_activate_cmd,
   // internal word access request to external memory
   input  wire logic        i_xreq,
   input  wire logic [15:0] i_xaddr,
   input  wire logic [15:0] i_xwdata,
   // wishbone slave
   input  wire logic        i_wb_cyc,
   input  wire logic        i_wb_stb,
   input  wire logic        i_wb_we,
   input  wire logic [7:0]  i_wb_adr,
   input  wire logic [3:0]  i_wb_sel,
   input  wire logic [31:0] i_wb_dat,
   output logic             o_wb_ack,
   output logic [31:0]      o_wb_dat,
   // mode outputs
   output logic [2:0]       o_mode,
   output logic             o_special,
   output logic             o_single_chip,
   output logic             o_expanded,
   output logic             o_narrow,
   output logic             o_peripheral,
   output logic             o_ext_master_en,
   output logic             o_relax_protect,
   output logic             o_background_debug_state,
   output logic             o_bdm_enabled,
   // map gating
   output logic             o_port_ab_in_map,
   output logic             o_port_e_in_map,
   // external bus
   output logic             o_port_a_bus,
   output logic             o_port_b_bus,
   output logic [7:0]       o_port_a_out,
   output logic [7:0]       o_port_b_out,
   output logic             o_port_a_oe_n,
   output logic             o_port_b_oe_n,
   output logic             o_xbusy,
   output logic             o_xdone
);
   typedef struct packed {
      logic [2:0]  pin_s1;
      logic [2:0]  pin_s2;
      logic        rst_d;
      logic [2:0]  mode;
      logic        flag_wr_seen;
      logic        ab_wr_seen;
      logic        emulate_port_e_bit;
      logic        eme_wr_seen;
      logic        bdm_en;
      logic        bdm_act;
      logic        ack;
      logic [31:0] rdat;
      oms_bus_t    bus;
      logic [15:0] addr;
      logic [7:0]  lo_byte;
      logic [7:0]  pa;
      logic [7:0]  pb;
      logic        done;
   } oms_state_t;

   oms_state_t st;
   oms_state_t next_st;

   logic       special;
   logic       single;
   logic       periph;
   logic       narrow;
   logic       wide;
   logic       wb_req;
   logic [2:0] wr_mode;

   always_comb begin
      special = ~st.mode[2];
      periph  = (st.mode[1:0] == 2'h2);
      single  = (st.mode[1:0] == 2'h0);
      narrow  = (st.mode[1:0] == 2'h1);
      wide    = (st.mode[1:0] == 2'h3);
   end

   assign wb_req = i_wb_cyc & i_wb_stb & ~st.ack;

   always_comb begin
      next_st      = st;
      next_st.ack  = 1'b0;
      next_st.done = 1'b0;
      wr_mode      = st.mode;
      // two flops before the pins are read
      next_st.pin_s1 = {i_background_pin, i_mode_select_b, i_mode_select_a};
      next_st.pin_s2 = st.pin_s1;
      next_st.rst_d  = 1'b0;
      // capture on reset release
      // rst_d marks the first clock after release, so the code is taken once
      if (st.rst_d) begin
         next_st.mode    = (st.pin_s2 == OMS_NRSV) ? OMS_SPER : st.pin_s2;
         // emulate bit comes up set in special modes only
         next_st.emulate_port_e_bit     = ~st.pin_s2[2] & OMS_EME_SPECIAL_RST;
         // special single chip starts in active debug
         next_st.bdm_act = (st.pin_s2 == OMS_SSC);
         next_st.bdm_en  = (st.pin_s2 == OMS_SSC);
      end
      if (i_bdm_enable_cmd) begin
         next_st.bdm_en = 1'b1;
      end
      if (i_bdm_activate_cmd && (st.bdm_en || i_bdm_enable_cmd)) begin
         next_st.bdm_act = 1'b1;
      end
      if (wb_req) begin
         next_st.ack  = 1'b1;
         next_st.rdat = 32'h0;
         case (i_wb_adr)
            OMS_MODE_OFS: begin
               // mode register absent from the map in peripheral mode
               // mode readback
               if (!periph) begin
                  next_st.rdat[OMS_SPECIAL_MODE_FLAG_N_BIT] = st.mode[2];
                  next_st.rdat[OMS_MODE_SELECT_B_BIT]  = st.mode[1];
                  next_st.rdat[OMS_MODE_SELECT_A_BIT]  = st.mode[0];
                  next_st.rdat[OMS_EME_BIT]   = st.emulate_port_e_bit;
               end
               if (i_wb_we && i_wb_sel[0] && !periph) begin
                  // flag in special modes only, first write ignored
                  if (special) begin
                     next_st.flag_wr_seen = 1'b1;
                     if (st.flag_wr_seen) begin
                        wr_mode[2] = i_wb_dat[OMS_SPECIAL_MODE_FLAG_N_BIT];
                     end
                  end
                  // b/a write once in normal, anytime after first in special
                  if (!st.ab_wr_seen || special) begin
                     next_st.ab_wr_seen = 1'b1;
                     if (!special || st.ab_wr_seen) begin
                        wr_mode[1:0] = {i_wb_dat[OMS_MODE_SELECT_B_BIT], i_wb_dat[OMS_MODE_SELECT_A_BIT]};
                     end
                  end
                  // never select peripheral or reserved by write
                  // such a write leaves all three mode bits unchanged: only reset can reach peripheral
                  if (wr_mode[1:0] != 2'h2) begin
                     next_st.mode = wr_mode;
                  end
                  // emulate bit: normal write once, special after first
                  if (special ? st.eme_wr_seen : !st.eme_wr_seen) begin
                     next_st.emulate_port_e_bit = i_wb_dat[OMS_EME_BIT];
                  end
                  next_st.eme_wr_seen = 1'b1;
               end
            end
            OMS_STAT_OFS: begin
               next_st.rdat[7:0] = {st.bdm_act, st.bdm_en, st.bus == OMS_IDLE ? 1'b0 : 1'b1, 2'h0, st.mode};
            end
            default: next_st.rdat = 32'h0;
         endcase
      end
      // narrow word: high byte, then low byte at address plus one
      case (st.bus)
         OMS_IDLE: begin
            if (i_xreq && (narrow || wide)) begin
               next_st.addr = i_xaddr;
               next_st.pa   = i_xaddr[15:8];
               next_st.pb   = i_xaddr[7:0];
               next_st.lo_byte = i_xwdata[7:0];
               if (narrow) begin
                  next_st.pa  = i_xwdata[15:8];
                  next_st.bus = OMS_HI;
               end else begin
                  // wide word on a and b together
                  next_st.pa  = i_xwdata[15:8];
                  next_st.pb  = i_xwdata[7:0];
                  next_st.done = 1'b1;
               end
            end
         end
         OMS_HI: begin
            // address low byte on b, data on a
            next_st.addr = st.addr + 16'h1;
            next_st.pb   = 8'(st.addr + 16'h1);
            next_st.pa   = st.lo_byte;
            next_st.bus  = OMS_LO;
         end
         OMS_LO: begin
            next_st.done = 1'b1;
            next_st.bus  = OMS_IDLE;
         end
         default: next_st.bus = OMS_IDLE;
      endcase
      if (i_sys_rst) begin
         next_st              = '0;
         // synchroniser keeps running so the pins are settled at release
         next_st.pin_s1       = {i_background_pin, i_mode_select_b, i_mode_select_a};
         next_st.pin_s2       = st.pin_s1;
         next_st.rst_d        = 1'b1;
         next_st.mode         = OMS_NSC;
         next_st.bus          = OMS_IDLE;
      end
   end

   always_ff @(posedge i_clk) begin
      st <= next_st;
   end

   always_comb begin
      o_mode          = st.mode;
      o_special       = special;
      // single chip: ports stay general purpose
      o_single_chip   = single;
      o_expanded      = narrow | wide;
      o_narrow        = narrow;
      o_peripheral    = periph;
      o_ext_master_en = periph;
      o_relax_protect = special;
      o_background_debug_state = st.bdm_act;
      o_bdm_enabled   = st.bdm_en;
      // port a/b unmapped unless single chip
      o_port_ab_in_map = single;
      o_port_e_in_map  = ~(periph | ((narrow | wide) & st.emulate_port_e_bit));
      o_port_a_bus    = ~single;
      o_port_b_bus    = ~single;
      o_port_a_out    = st.pa;
      o_port_b_out    = st.pb;
      o_port_a_oe_n   = ~(narrow | wide);
      o_port_b_oe_n   = ~(narrow | wide);
      o_xbusy         = (st.bus != OMS_IDLE);
      o_xdone         = st.done;
      o_wb_ack        = st.ack;
      o_wb_dat        = st.rdat;
   end

   chk_mode_bits_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (wb_req && !i_wb_we && i_wb_adr == OMS_MODE_OFS && !periph)
      |=> o_wb_dat[7:5] == $past(st.mode))
      else $error("mode bits misplaced");
   chk_reserved_forced: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      st.mode != OMS_NRSV) else $error("reserved mode held");
   chk_bdm_after_reset: assert property (@(posedge i_clk)
      ($fell(st.rst_d) && $past(st.pin_s2) == OMS_SSC && !i_sys_rst) |-> st.bdm_act)
      else $error("debug not active");
   chk_single_no_drive: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      single |-> (o_port_a_oe_n && o_port_b_oe_n)) else $error("single chip drives bus");
   chk_narrow_seq: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (st.bus == OMS_HI) |=> (st.bus == OMS_LO) ##1 o_xdone) else $error("narrow sequence broken");
   chk_ab_unmapped: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (periph || narrow || wide) |-> !o_port_ab_in_map) else $error("port a/b mapped");
   chk_e_unmapped: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      periph |-> !o_port_e_in_map) else $error("port e mapped");
   // normal stays normal
   // the capture cycle after release is skipped: the mode there comes from the pins
   chk_normal_flag: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (!special && !st.rst_d) |=> !special) else $error("normal left by write");
   chk_ack_one: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_wb_ack |=> !o_wb_ack) else $error("ack held");
   chk_wide_done: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (st.bus == OMS_IDLE && i_xreq && wide)
      |=> (o_xdone && o_port_a_out == $past(i_xwdata[15:8]) && o_port_b_out == $past(i_xwdata[7:0])))
      else $error("wide word not sent");
   chk_narrow_drive: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      narrow |-> (!o_port_a_oe_n && !o_port_b_oe_n)) else $error("narrow bus not driven");
   chk_narrow_addr: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (st.bus == OMS_HI) |-> (o_port_b_out == st.addr[7:0])) else $error("narrow address lost");
   chk_periph_master: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      periph |-> (o_ext_master_en && o_port_a_bus && o_port_b_bus)) else $error("peripheral bus not given");
   chk_relax_special: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_relax_protect == !o_mode[2]) else $error("protection level wrong");
   chk_mode_held: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      (!st.rst_d && !(wb_req && i_wb_we && i_wb_adr == OMS_MODE_OFS)) |=> $stable(st.mode))
      else $error("mode changed unasked");
   chk_act_needs_en: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      ($rose(st.bdm_act) && !$past(st.rst_d)) |-> $past(st.bdm_en || i_bdm_enable_cmd))
      else $error("debug active without enable");
   chk_single_mapped: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      single |-> (o_port_ab_in_map && o_port_e_in_map)) else $error("single chip port unmapped");
   // main scenarios reached
   cov_narrow: cover property (@(posedge i_clk) narrow && o_xdone);
   cov_wide: cover property (@(posedge i_clk) wide && o_xdone);
   cov_periph: cover property (@(posedge i_clk) periph);
   cov_bdm_act: cover property (@(posedge i_clk) $rose(st.bdm_act));
   cov_mode_write: cover property (@(posedge i_clk) wb_req && i_wb_we && i_wb_adr == OMS_MODE_OFS && special);
endmodule : oms_mode_select

// file: src/oms_pkg.sv
// package for the operating mode select block
package oms_pkg;
   // register word offsets (byte addresses)
   localparam logic [7:0] OMS_MODE_OFS   = 8'h00;
   localparam logic [7:0] OMS_CFG_OFS    = 8'h04;
   localparam logic [7:0] OMS_STAT_OFS   = 8'h08;
   // mode register field positions
   localparam int OMS_SPECIAL_MODE_FLAG_N_BIT = 7;
   localparam int OMS_MODE_SELECT_B_BIT  = 6;
   localparam int OMS_MODE_SELECT_A_BIT  = 5;
   localparam int OMS_EME_BIT   = 0;
   // mode codes {special_mode_flag_n, b, a}
   localparam logic [2:0] OMS_NSC   = 3'h4;
   localparam logic [2:0] OMS_NNAR  = 3'h5;
   localparam logic [2:0] OMS_NRSV  = 3'h6;
   localparam logic [2:0] OMS_NWIDE = 3'h7;
   localparam logic [2:0] OMS_SSC   = 3'h0;
   localparam logic [2:0] OMS_SNAR  = 3'h1;
   localparam logic [2:0] OMS_SPER  = 3'h2;
   localparam logic [2:0] OMS_SWIDE = 3'h3;
   // reset value of the emulate port e bit in special modes
   localparam logic OMS_EME_SPECIAL_RST = 1'h1;
   // narrow bus sequencer states
   typedef enum logic [2:0] {
      OMS_IDLE = 3'h1,
      OMS_HI   = 3'h2,
      OMS_LO   = 3'h4
   } oms_bus_t;
endpackage : oms_pkg

// file: bench/oms_ext_mem.sv
// external memory model on the multiplexed port bus
`timescale 1ns/1ps
module oms_ext_mem (
   // clock and control
   input  wire logic       i_clk,
   input  wire logic       i_clr,
   // bus bytes
   input  wire logic       i_cap,
   input  wire logic [7:0] i_pa,
   input  wire logic [7:0] i_pb
);
   logic [7:0] cap_a [4];
   logic [7:0] cap_b [4];
   int         n_cap = 0;
   // latch each driven bus cycle, in order
   always @(posedge i_clk) begin
      if (i_clr) begin
         n_cap <= 0;
      end else if (i_cap && n_cap < 4) begin
         cap_a[n_cap] <= i_pa;
         cap_b[n_cap] <= i_pb;
         n_cap        <= n_cap + 1;
      end
   end
endmodule : oms_ext_mem

// file: bench/tb_top.sv
// self-checking bench for the operating mode select block
`timescale 1ns/1ps
module tb_top;
   import oms_pkg::*;
   logic i_clk = 0, i_sys_rst = 1, i_background_pin = 1, i_mode_select_b = 0, i_mode_select_a = 0;
   logic i_bdm_enable_cmd = 0, i_bdm_activate_cmd = 0, i_xreq = 0, i_wb_cyc = 0, i_wb_stb = 0;
   logic i_wb_we = 0, cap_clr = 0, per, sc, ex;
   logic [15:0] i_xaddr = 0, i_xwdata = 0;
   logic [7:0]  i_wb_adr = 0, o_port_a_out, o_port_b_out;
   logic [3:0]  i_wb_sel = 4'h1;
   logic [31:0] i_wb_dat = 0, o_wb_dat, rdat;
   logic [2:0]  o_mode, c;
   logic o_wb_ack, o_special, o_single_chip, o_expanded, o_narrow, o_peripheral, o_ext_master_en;
   logic o_relax_protect, o_background_debug_state, o_bdm_enabled, o_port_ab_in_map, o_port_e_in_map;
   logic o_port_a_bus, o_port_b_bus, o_port_a_oe_n, o_port_b_oe_n, o_xbusy, o_xdone;
   int   n_fail = 0, compares = 0;

   oms_mode_select u_oms_mode_select (.i_clk, .i_sys_rst, .i_background_pin, .i_mode_select_b,
      .i_mode_select_a, .i_bdm_enable_cmd, .i_bdm_activate_cmd, .i_xreq, .i_xaddr, .i_xwdata,
      .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_ack, .o_wb_dat,
      .o_mode, .o_special, .o_single_chip, .o_expanded, .o_narrow, .o_peripheral, .o_ext_master_en,
      .o_relax_protect, .o_background_debug_state, .o_bdm_enabled, .o_port_ab_in_map,
      .o_port_e_in_map, .o_port_a_bus, .o_port_b_bus, .o_port_a_out, .o_port_b_out,
      .o_port_a_oe_n, .o_port_b_oe_n, .o_xbusy, .o_xdone);
   oms_ext_mem u_oms_ext_mem (.i_clk, .i_clr(cap_clr), .i_cap((o_xbusy | o_xdone) & ~o_port_a_oe_n),
      .i_pa(o_port_a_out), .i_pb(o_port_b_out));

   always #25 i_clk = ~i_clk;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic end_of_test;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_of_test

   // classic single wishbone cycle; request held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      i_wb_cyc <= 1;
      i_wb_stb <= 1;
      i_wb_we  <= w;
      i_wb_adr <= a;
      i_wb_dat <= d;
      do @(posedge i_clk); while (o_wb_ack !== 1'b1 && n++ < 20);
      rdat = o_wb_dat;
      chk("wb ack", o_wb_ack, 1);
      i_wb_cyc <= 0;
      i_wb_stb <= 0;
      i_wb_we  <= 0;
      @(posedge i_clk);
   endtask : wb

   task automatic boot(input logic [2:0] m);
      @(posedge i_clk);
      i_sys_rst <= 1;
      {i_background_pin, i_mode_select_b, i_mode_select_a} <= m;
      repeat (5) @(posedge i_clk);
      i_sys_rst <= 0;
      repeat (3) @(posedge i_clk);
   endtask : boot

   task automatic pulse(input logic en, input logic act);
      @(posedge i_clk);
      i_bdm_enable_cmd   <= en;
      i_bdm_activate_cmd <= act;
      @(posedge i_clk);
      i_bdm_enable_cmd   <= 0;
      i_bdm_activate_cmd <= 0;
      repeat (2) @(posedge i_clk);
   endtask : pulse

   // word to external memory; address low byte at its carry boundary
   task automatic xfer(input logic [15:0] a, input logic [15:0] d, input logic nar);
      int n;
      n = 0;
      @(posedge i_clk);
      cap_clr <= 1;
      @(posedge i_clk);
      cap_clr <= 0;
      i_xreq  <= 1;
      i_xaddr <= a;
      i_xwdata <= d;
      @(posedge i_clk);
      i_xreq <= 0;
      do @(posedge i_clk); while (o_xdone !== 1'b1 && n++ < 20);
      @(posedge i_clk);
      chk("xfer done", o_xdone, 0);
      chk("hi byte", u_oms_ext_mem.cap_a[0], d[15:8]);
      chk("b first", u_oms_ext_mem.cap_b[0], nar ? a[7:0] : d[7:0]);
      if (nar) chk("lo byte", u_oms_ext_mem.cap_a[1], d[7:0]);
      if (nar) chk("addr inc", u_oms_ext_mem.cap_b[1], 8'(a[7:0] + 8'h1));
   endtask : xfer

   initial begin
      for (int i = 0; i < 8; i++) begin
         c = 3'(i);
         per = (c[1:0] == 2'h2);
         sc = (c[1:0] == 2'h0);
         ex = !sc && !per;
         boot(c);
         chk("periph", o_peripheral, per);
         chk("single", o_single_chip, sc);
         chk("oe a", o_port_a_oe_n, !ex);
         chk("oe b", o_port_b_oe_n, !ex);
         chk("a bus", o_port_a_bus, !sc);
         chk("b bus", o_port_b_bus, !sc);
         chk("master", o_ext_master_en, per);
         chk("special", o_special, per || !c[2]);
         chk("debug en", o_bdm_enabled, c == 3'h0);
         chk("expanded", o_expanded, ex);
         chk("narrow", o_narrow, c[1:0] == 2'h1);
         chk("ab map", o_port_ab_in_map, sc);
         chk("e map", o_port_e_in_map, !(per || (ex && !c[2])));
         chk("debug", o_background_debug_state, c == 3'h0);
         wb(0, OMS_MODE_OFS, 0);
         if (!per) chk("mode out", o_mode, c);
         if (!per) chk("relax", o_relax_protect, !c[2]);
         if (!per) chk("mode reg", rdat[7:5], c);
         if (ex) xfer(16'h12ff, 16'ha55a, c[1:0] == 2'h1);
      end
      boot(OMS_NNAR);
      wb(1, OMS_MODE_OFS, 32'he0);
      chk("once", o_mode, OMS_NWIDE);
      wb(1, OMS_MODE_OFS, 32'h20);
      chk("twice", o_mode, OMS_NWIDE);
      wb(0, OMS_CFG_OFS, 0);
      boot(OMS_SWIDE);
      wb(1, OMS_MODE_OFS, 32'h21);
      chk("first", o_mode, OMS_SWIDE);
      wb(1, OMS_MODE_OFS, 32'h21);
      chk("second", o_mode, OMS_SNAR);
      wb(1, OMS_MODE_OFS, 32'h41);
      chk("no periph", o_mode, OMS_SNAR);
      boot(OMS_NSC);
      {i_background_pin, i_mode_select_b, i_mode_select_a} <= 3'h7;
      pulse(0, 1);
      chk("no act", o_background_debug_state, 0);
      pulse(1, 0);
      pulse(0, 1);
      chk("act", o_background_debug_state, 1);
      chk("en", o_bdm_enabled, 1);
      wb(0, OMS_STAT_OFS, 0);
      chk("status", rdat[7:0], {2'h3, 3'h0, OMS_NSC});
      chk("held", o_mode, OMS_NSC);
      end_of_test();
   end

   // whole run is well under a thousand cycles
   initial begin
      repeat (5000) @(posedge i_clk);
      n_fail++;
      end_of_test();
   end
endmodule : tb_top
